/* File: src/pps_top.sv */
// Notes on behaviour
// - panic status bit follows input, resets 0
// - panic halts instantly, then alarm action
// - no new motion while panic active
// - panic status zero when input unmapped
// - panic input polarity is configurable
// - pause status bit, one while paused
// - pause input or command sets pause
// - resume, start, clear or new motion clears
// - pause status output polarity configurable
// - clear input discards rest of motion
// - ready low while panic active
`timescale 1ns/1ps
module pps_top
	import pps_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [pps_pkg::WB_AW-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [pps_pkg::WB_DW-1:0] dat_i,
	output logic [pps_pkg::WB_DW-1:0] dat_o,
	output logic ack_o,
	input wire pps_pkg::pps_pins_s pins_i,
	input wire logic seq_running_i,
	input wire logic motion_done_i,
	input wire logic decel_done_i,
	output pps_pkg::pps_motion_s motion_o,
	output logic motion_hold_output_o,
	output logic ready_o,
	output logic alarm_o,
	output logic deenergize_o,
	output logic irq_o
);
	// synchronised pins
	pps_pins_s pin_s;
	pps_pins_s pin_prev_q;
	pps_pins_s pin_prev_d;

	pps_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(pins_i),
		.q_o(pin_s)
	);

	// configuration
	logic [REG_W-1:0] ctrl_q;
	logic [REG_W-1:0] ctrl_d;
	logic panic_pol;
	logic panic_map;
	logic hold_pol;
	logic [1:0] alarm_action_setting;

	assign panic_pol = ctrl_q[CTRL_PANIC_POL];
	assign panic_map = ctrl_q[CTRL_PANIC_MAP];
	assign hold_pol = ctrl_q[CTRL_HOLD_POL];
	assign alarm_action_setting = ctrl_q[CTRL_ALARM_HI:CTRL_ALARM_LO];

	// panic level after polarity and mapping
	logic panic_stop_state;
	logic panic_rise;

	assign panic_stop_state = panic_map & ~(pin_s.panic ^ panic_pol);
	assign panic_rise = panic_stop_state &
		~(panic_map & ~(pin_prev_q.panic ^ panic_pol));

	// pin edges, pins are active high after sync
	logic pause_rise;
	logic clear_rise;
	logic start_rise;

	assign pause_rise = pin_s.pause & ~pin_prev_q.pause;
	assign clear_rise = pin_s.hold_clear & ~pin_prev_q.hold_clear;
	assign start_rise = pin_s.start & ~pin_prev_q.start;

	// bus slave
	logic ack_q;
	logic ack_d;
	logic [WB_DW-1:0] rdat_q;
	logic [WB_DW-1:0] rdat_d;
	logic bus_req;
	logic wr_stb;
	logic wr_lo;

	assign bus_req = cyc_i & stb_i;
	// write lands on the edge where the master sees ack
	assign wr_stb = bus_req & we_i & ack_q;
	assign wr_lo = wr_stb & sel_i[0];

	logic cmd_wr;
	logic [REG_W-1:0] cmd_bits;

	assign cmd_wr = wr_lo & (adr_i == REG_CMD);
	assign cmd_bits = cmd_wr ? dat_i[REG_W-1:0] : '0;

	// command strobes and combined requests
	logic pause_req;
	logic resume_req;
	logic clear_req;
	logic start_req;
	logic alarm_rst_req;

	assign pause_req = pause_rise | cmd_bits[CMD_PAUSE];
	assign resume_req = cmd_bits[CMD_RESUME] |
		(start_rise & seq_running_i);
	assign clear_req = clear_rise | cmd_bits[CMD_CLEAR];
	assign start_req = cmd_bits[CMD_START] |
		(start_rise & ~seq_running_i);
	assign alarm_rst_req = cmd_bits[CMD_ALARM_RST];

	// motion state
	pps_state_e state_q;
	pps_state_e state_d;
	logic hold_q;
	logic hold_d;
	logic alarm_q;
	logic alarm_d;
	logic deen_q;
	logic deen_d;
	pps_motion_s mot_q;
	pps_motion_s mot_d;
	logic refused;
	logic done_ev;
	logic hold_set_ev;

	always_comb begin
		state_d = state_q;
		hold_d = hold_q;
		alarm_d = alarm_q;
		deen_d = deen_q;
		mot_d = '0;
		refused = 1'b0;
		done_ev = 1'b0;
		hold_set_ev = 1'b0;
		if (panic_rise) begin
			// no ramp: pulse generator cut at once
			mot_d.hard_stop = 1'b1;
			case (alarm_action_setting)
				ALM_FLAG: begin
					state_d = ST_ALARM;
					alarm_d = 1'b1;
				end
				ALM_DEEXCITE: begin
					state_d = ST_ALARM;
					alarm_d = 1'b1;
					deen_d = 1'b1;
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_req) begin
						if (panic_stop_state) begin
							refused = 1'b1;
						end else begin
							hold_d = 1'b0;
							mot_d.start = 1'b1;
							state_d = ST_RUN;
						end
					end
				end
				ST_RUN: begin
					if (motion_done_i) begin
						done_ev = 1'b1;
						state_d = ST_IDLE;
					end else if (pause_req) begin
						state_d = ST_DECEL;
					end
				end
				ST_DECEL: begin
					if (decel_done_i) begin
						hold_d = 1'b1;
						hold_set_ev = 1'b1;
						state_d = ST_PAUSED;
					end
				end
				ST_PAUSED: begin
					if (clear_req) begin
						mot_d.discard = 1'b1;
						hold_d = 1'b0;
						state_d = ST_IDLE;
					end else if (resume_req | start_req) begin
						if (panic_stop_state) begin
							refused = 1'b1;
						end else begin
							hold_d = 1'b0;
							// a fresh start drops the paused remainder
							mot_d.discard = start_req;
							mot_d.start = start_req;
							state_d = ST_RUN;
						end
					end
				end
				ST_ALARM: begin
					if (start_req) begin
						refused = 1'b1;
					end
					if (alarm_rst_req & ~panic_stop_state) begin
						alarm_d = 1'b0;
						deen_d = 1'b0;
						state_d = ST_IDLE;
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
		// a clear in any other state still drops the hold flag, set wins
		if (clear_req & (state_q != ST_PAUSED) & ~hold_set_ev) begin
			hold_d = 1'b0;
		end
		mot_d.run = (state_d == ST_RUN) | (state_d == ST_DECEL);
		mot_d.decel = (state_d == ST_DECEL);
		if (rst_i) begin
			state_d = ST_IDLE;
			hold_d = 1'b0;
			alarm_d = 1'b0;
			deen_d = 1'b0;
			mot_d = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		state_q <= state_d;
		hold_q <= hold_d;
		alarm_q <= alarm_d;
		deen_q <= deen_d;
		mot_q <= mot_d;
	end

	// ready and pin outputs
	logic ready_q;
	logic ready_d;
	logic hold_out_q;
	logic hold_out_d;

	always_comb begin
		ready_d = (state_q == ST_IDLE) & ~alarm_q & ~pin_s.start &
			~panic_stop_state;
		hold_out_d = ~(hold_q ^ hold_pol);
		pin_prev_d = pin_s;
		if (rst_i) begin
			ready_d = 1'b0;
			hold_out_d = 1'b0;
			pin_prev_d = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		ready_q <= ready_d;
		hold_out_q <= hold_out_d;
		pin_prev_q <= pin_prev_d;
	end

	// interrupt events
	logic [IRQ_W-1:0] ev_vec;
	logic [IRQ_W-1:0] irq_clr;
	logic [IRQ_W-1:0] irq_sts;
	logic [IRQ_W-1:0] irq_mask;
	logic mask_we;

	always_comb begin
		ev_vec = '0;
		ev_vec[EV_PANIC] = panic_rise;
		ev_vec[EV_HOLD] = hold_set_ev;
		ev_vec[EV_REFUSED] = refused;
		ev_vec[EV_DONE] = done_ev;
	end

	assign irq_clr = (wr_lo & (adr_i == REG_IRQ_STS)) ?
		dat_i[IRQ_W-1:0] : '0;
	assign mask_we = wr_lo & (adr_i == REG_IRQ_MASK);

	pps_irq u_irq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(ev_vec),
		.clear_i(irq_clr),
		.mask_we_i(mask_we),
		.mask_i(dat_i[IRQ_W-1:0]),
		.status_o(irq_sts),
		.mask_o(irq_mask),
		.irq_o(irq_o)
	);

	// status word seen by software
	logic [REG_W-1:0] status_word;

	always_comb begin
		status_word = '0;
		status_word[STAT_PANIC] = panic_stop_state;
		status_word[STAT_HOLD] = hold_q;
		status_word[STAT_RUN] = mot_q.run;
		status_word[STAT_ALARM] = alarm_q;
		status_word[STAT_READY] = ready_q;
	end

	// register bus: one wait state, unmapped reads give zero
	always_comb begin
		ack_d = bus_req & ~ack_q;
		rdat_d = rdat_q;
		ctrl_d = ctrl_q;
		if (bus_req & ~ack_q & ~we_i) begin
			rdat_d = '0;
			case (adr_i)
				REG_CTRL: begin
					rdat_d[REG_W-1:0] = ctrl_q;
				end
				REG_STATUS: begin
					rdat_d[REG_W-1:0] = status_word;
				end
				REG_IRQ_STS: begin
					rdat_d[IRQ_W-1:0] = irq_sts;
				end
				REG_IRQ_MASK: begin
					rdat_d[IRQ_W-1:0] = irq_mask;
				end
				default: begin
					rdat_d = '0;
				end
			endcase
		end
		if (wr_lo & (adr_i == REG_CTRL)) begin
			ctrl_d = dat_i[REG_W-1:0];
		end
		if (rst_i) begin
			ack_d = 1'b0;
			rdat_d = '0;
			ctrl_d = CTRL_RESET;
		end
	end

	always_ff @(posedge clk_i) begin
		ack_q <= ack_d;
		rdat_q <= rdat_d;
		ctrl_q <= ctrl_d;
	end

	assign ack_o = ack_q;
	assign dat_o = rdat_q;
	assign motion_o = mot_q;
	assign motion_hold_output_o = hold_out_q;
	assign ready_o = ready_q;
	assign alarm_o = alarm_q;
	assign deenergize_o = deen_q;
endmodule : pps_top

/* File: src/pps_pkg.sv */
package pps_pkg;
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;
	localparam int REG_W = 8;

	localparam logic [WB_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [WB_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [WB_AW-1:0] REG_CMD = 8'h08;
	localparam logic [WB_AW-1:0] REG_IRQ_STS = 8'h0C;
	localparam logic [WB_AW-1:0] REG_IRQ_MASK = 8'h10;

	localparam int CTRL_PANIC_POL = 0;
	localparam int CTRL_PANIC_MAP = 1;
	localparam int CTRL_HOLD_POL = 2;
	localparam int CTRL_ALARM_LO = 4;
	localparam int CTRL_ALARM_HI = 5;
	localparam logic [REG_W-1:0] CTRL_RESET = 8'h07;

	localparam int STAT_PANIC = 0;
	localparam int STAT_HOLD = 1;
	localparam int STAT_RUN = 2;
	localparam int STAT_ALARM = 3;
	localparam int STAT_READY = 4;

	localparam int CMD_PAUSE = 0;
	localparam int CMD_RESUME = 1;
	localparam int CMD_CLEAR = 2;
	localparam int CMD_START = 3;
	localparam int CMD_ALARM_RST = 4;

	localparam int IRQ_W = 4;
	localparam int EV_PANIC = 0;
	localparam int EV_HOLD = 1;
	localparam int EV_REFUSED = 2;
	localparam int EV_DONE = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

	localparam logic [1:0] ALM_NONE = 2'h0;
	localparam logic [1:0] ALM_FLAG = 2'h1;
	localparam logic [1:0] ALM_DEEXCITE = 2'h2;

	localparam int SYNC_W = 4;

	typedef struct packed {
		logic panic;
		logic pause;
		logic hold_clear;
		logic start;
	} pps_pins_s;

	typedef struct packed {
		logic run;
		logic decel;
		logic hard_stop;
		logic discard;
		logic start;
	} pps_motion_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_DECEL,
		ST_PAUSED,
		ST_ALARM
	} pps_state_e;
endpackage : pps_pkg

/* File: src/pps_sync.sv */
`timescale 1ns/1ps
module pps_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	// first stage feeds only the second stage
	always_comb begin
		meta_d = d_i;
		sync_d = meta_q;
		if (rst_i) begin
			meta_d = '0;
			sync_d = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign q_o = sync_q;
endmodule : pps_sync

/* File: src/pps_irq.sv */
`timescale 1ns/1ps
module pps_irq
	import pps_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [pps_pkg::IRQ_W-1:0] event_i,
	input wire logic [pps_pkg::IRQ_W-1:0] clear_i,
	input wire logic mask_we_i,
	input wire logic [pps_pkg::IRQ_W-1:0] mask_i,
	output logic [pps_pkg::IRQ_W-1:0] status_o,
	output logic [pps_pkg::IRQ_W-1:0] mask_o,
	output logic irq_o
);
	logic [IRQ_W-1:0] sts_q;
	logic [IRQ_W-1:0] sts_d;
	logic [IRQ_W-1:0] mask_q;
	logic [IRQ_W-1:0] mask_d;

	// set beats clear so a coincident event is never lost
	always_comb begin
		sts_d = (sts_q & ~clear_i) | event_i;
		mask_d = mask_we_i ? mask_i : mask_q;
		if (rst_i) begin
			sts_d = '0;
			mask_d = IRQ_MASK_RESET;
		end
	end

	always_ff @(posedge clk_i) begin
		sts_q <= sts_d;
		mask_q <= mask_d;
	end

	assign status_o = sts_q;
	assign mask_o = mask_q;
	assign irq_o = |(sts_q & mask_q);
endmodule : pps_irq

/* File: dv/pps_far_model.sv */
`timescale 1ns/1ps
module pps_far_model
	import pps_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire pps_pkg::pps_motion_s motion_i,
	input wire logic [3:0] lag_i,
	input wire logic finish_i,
	output logic decel_done_o,
	output logic motion_done_o
);
	logic [3:0] cnt_q;
	logic busy;
	// done is a level; it stays up until the block leaves the state
	assign busy = motion_i.decel || (motion_i.run && finish_i);
	always_ff @(posedge clk_i) begin
		if (rst_i || !busy) begin
			cnt_q <= 4'h0;
		end else if (cnt_q != 4'hF) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	assign decel_done_o = motion_i.decel && cnt_q >= lag_i;
	assign motion_done_o = busy && !motion_i.decel && cnt_q >= lag_i;
endmodule : pps_far_model

/* File: dv/pps_top_props.sv */
`timescale 1ns/1ps
module pps_chk
	import pps_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [pps_pkg::WB_DW-1:0] dat_o,
	input wire logic ack_o,
	input wire logic ready_o,
	input wire pps_pkg::pps_motion_s motion_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_one; ack_o |=> !ack_o; endproperty
	property p_ack_due; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	property p_dat_hi; ack_o |-> dat_o[31:8] == 24'h0; endproperty
	property p_hard_run; motion_o.hard_stop |=> !motion_o.run; endproperty
	property p_hard_nogo; motion_o.hard_stop |=> (!motion_o.start)[*3];
	endproperty
	property p_hard_rdy; motion_o.hard_stop |-> !ready_o; endproperty
	// a fresh start may come with the discard and keep the motor running
	property p_disc; motion_o.discard |=> !motion_o.discard &&
		(!motion_o.run || $past(motion_o.start)); endproperty
	property p_start_run; motion_o.start |-> motion_o.run; endproperty
	property p_start_one; $rose(motion_o.start) |=> !motion_o.start;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("ack held too long");
	a_ack_due: assert property (p_ack_due)
		else $error("ack late");
	a_dat_hi: assert property (p_dat_hi)
		else $error("read data above bit 7");
	a_hard_run: assert property (p_hard_run)
		else $error("run after hard stop");
	a_hard_nogo: assert property (p_hard_nogo)
		else $error("start right after hard stop");
	a_hard_rdy: assert property (p_hard_rdy)
		else $error("ready during hard stop");
	a_disc: assert property (p_disc)
		else $error("discard not a clean pulse");
	a_start_run: assert property (p_start_run)
		else $error("start without run");
	a_start_one: assert property (p_start_one)
		else $error("start pulse too long");
	c_hard: cover property (motion_o.hard_stop);
	c_disc: cover property (motion_o.discard);
	c_start: cover property (motion_o.start);
endmodule : pps_chk
bind pps_top pps_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o,
	.ack_o, .ready_o, .motion_o);

/* File: dv/panic_stop_pause_status_test.sv */
`timescale 1ns/1ps
module panic_stop_pause_status_test;
	import pps_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, seq, md, dd, fin, irq;
	logic hold_o, rdy, alm, deen;
	logic [7:0] adr;
	logic [31:0] dat, rdat, r;
	logic [3:0] lag;
	pps_pins_s pins;
	pps_motion_s mo;
	int error_cnt, checks_done;

	pps_top u_dut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
		.pins_i(pins), .seq_running_i(seq), .motion_done_i(md),
		.decel_done_i(dd), .motion_o(mo), .motion_hold_output_o(hold_o),
		.ready_o(rdy), .alarm_o(alm), .deenergize_o(deen), .irq_o(irq));
	pps_far_model u_far (.clk_i, .rst_i, .motion_i(mo), .lag_i(lag),
		.finish_i(fin), .decel_done_o(dd), .motion_done_o(md));

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		wb(1'b0, a, 32'h0);
		chk(r & m, e);
	endtask : rd
	task automatic st(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : st
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test

	task automatic t_reset;
		rd(REG_CTRL, 32'hFF, 32'h07);
		rd(REG_STATUS, 32'h3, 32'h0);
		rd(REG_IRQ_MASK, 32'hFF, 32'h0);
		rd(8'h20, 32'hFFFFFFFF, 32'h0);
		chk(32'(hold_o), 32'h0);
		chk(32'(rdy), 32'h1);
		$display("reset test done");
	endtask : t_reset
	task automatic t_hold;
		wb(1'b1, REG_IRQ_MASK, 32'h2);
		wb(1'b1, REG_CMD, 32'h8);
		pins.pause <= 1'b1;
		st(20);
		rd(REG_STATUS, 32'h2, 32'h2);
		pins.pause <= 1'b0;
		chk(32'(hold_o), 32'h1);
		chk(32'(irq), 32'h1);
		wb(1'b1, REG_CMD, 32'h2);
		st(2);
		rd(REG_STATUS, 32'h6, 32'h4);
		wb(1'b1, REG_CMD, 32'h1);
		st(2);
		chk(32'(mo.decel), 32'h1);
		st(18);
		rd(REG_STATUS, 32'h2, 32'h2);
		pins.hold_clear <= 1'b1;
		st(6);
		rd(REG_STATUS, 32'h6, 32'h0);
		pins.hold_clear <= 1'b0;
		wb(1'b1, REG_CMD, 32'h8);
		wb(1'b1, REG_CMD, 32'h1);
		seq <= 1'b1;
		st(20);
		@(posedge clk_i);
		pins.start <= 1'b1;
		st(6);
		rd(REG_STATUS, 32'h6, 32'h4);
		pins.start <= 1'b0;
		seq <= 1'b0;
		wb(1'b1, REG_CMD, 32'h1);
		st(20);
		wb(1'b1, REG_CTRL, 32'h3);
		st(2);
		chk(32'(hold_o), 32'h0);
		wb(1'b1, REG_CMD, 32'h8);
		st(2);
		chk(32'(hold_o), 32'h1);
		wb(1'b1, REG_CTRL, 32'h7);
		fin <= 1'b1;
		st(14);
		rd(REG_IRQ_STS, 32'hA, 32'hA);
		wb(1'b1, REG_IRQ_STS, 32'hF);
		fin <= 1'b0;
		st(1);
		chk(32'(irq), 32'h0);
		$display("hold test done");
	endtask : t_hold
	task automatic t_panic;
		wb(1'b1, REG_CTRL, 32'h27);
		wb(1'b1, REG_CMD, 32'h8);
		pins.panic <= 1'b1;
		st(6);
		chk(32'(mo.run), 32'h0);
		chk(32'(deen), 32'h1);
		chk(32'(alm), 32'h1);
		chk(32'(rdy), 32'h0);
		rd(REG_STATUS, 32'h1, 32'h1);
		wb(1'b1, REG_CMD, 32'h8);
		st(2);
		chk(32'(mo.run), 32'h0);
		rd(REG_IRQ_STS, 32'h4, 32'h4);
		pins.panic <= 1'b0;
		st(6);
		rd(REG_STATUS, 32'h1, 32'h0);
		wb(1'b1, REG_CMD, 32'h10);
		st(2);
		chk(32'(alm), 32'h0);
		chk(32'(deen), 32'h0);
		// low-active panic with the pin idle low reads as active
		wb(1'b1, REG_CTRL, 32'h6);
		st(4);
		rd(REG_STATUS, 32'h1, 32'h1);
		wb(1'b1, REG_CTRL, 32'h4);
		st(4);
		rd(REG_STATUS, 32'h1, 32'h0);
		wb(1'b1, REG_CTRL, 32'h7);
		wb(1'b1, REG_IRQ_STS, 32'hF);
		$display("panic test done");
	endtask : t_panic
	task automatic t_panic_modes;
		wb(1'b1, REG_CTRL, 32'h17);
		wb(1'b1, REG_CMD, 32'h8);
		pins.panic <= 1'b1;
		st(6);
		chk(32'({alm, deen, mo.run}), 32'h4);
		@(posedge clk_i);
		pins.panic <= 1'b0;
		st(6);
		wb(1'b1, REG_CMD, 32'h10);
		wb(1'b1, REG_CTRL, 32'h7);
		wb(1'b1, REG_IRQ_STS, 32'hF);
		// no alarm action: only the live panic level blocks the start
		wb(1'b1, REG_CMD, 32'h8);
		pins.panic <= 1'b1;
		st(6);
		chk(32'({alm, mo.run}), 32'h0);
		chk(32'(rdy), 32'h0);
		wb(1'b1, REG_CMD, 32'h8);
		st(2);
		chk(32'(mo.run), 32'h0);
		rd(REG_IRQ_STS, 32'h4, 32'h4);
		pins.panic <= 1'b0;
		st(6);
		chk(32'(rdy), 32'h1);
		wb(1'b1, REG_IRQ_STS, 32'hF);
		$display("panic modes test done");
	endtask : t_panic_modes

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		#200us;
		error_cnt++;
		end_of_test;
	end
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, seq, fin} = 5'h0;
		adr = 8'h0;
		dat = 32'h0;
		lag = 4'h9;
		pins = '0;
		error_cnt = 0;
		checks_done = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_hold;
		t_panic;
		t_panic_modes;
		end_of_test;
	end
endmodule : panic_stop_pause_status_test
